// file: rtl/adcseq_pkg.sv
// package for the conversion sequencer: register map, fields, counts
// assumes a 25 MHz system clock and an Avalon-MM word bus
package adcseq_pkg;
    // ==========================================================
    // register map, byte addresses (printed offsets not all /4)
    localparam logic [7:0] CTRL_IDX    = 8'h07;
    localparam logic [7:0] MUX_IDX     = 8'h08;
    localparam logic [7:0] RESH_IDX    = 8'h03;
    localparam logic [7:0] RESL_IDX    = 8'h24;
    localparam logic [7:0] IRQ_IDX     = 8'h30;
    localparam int         ADDR_W      = 10;
    localparam logic [9:0] CTRL_ADDR   = {CTRL_IDX, 2'b00};
    localparam logic [9:0] MUX_ADDR    = {MUX_IDX, 2'b00};
    localparam logic [9:0] RESH_ADDR   = {RESH_IDX, 2'b00};
    localparam logic [9:0] RESL_ADDR   = {RESL_IDX, 2'b00};
    localparam logic [9:0] IRQ_ADDR    = {IRQ_IDX, 2'b00};
    // ==========================================================
    // control/status bit positions
    localparam int EN_BIT    = 7;
    localparam int START_BIT = 6;
    localparam int FREE_BIT  = 5;
    localparam int DONE_BIT  = 4;
    localparam int IE_BIT    = 3;
    // irq helper register bit positions
    localparam int GIE_BIT   = 0;
    localparam int ACK_BIT   = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] MUX_RESET  = 4'h0;
    // ==========================================================
    // timing
    localparam int SYS_HZ      = 25_000_000;
    localparam int REF_HZ      = 2_000_000;
    localparam int REF_DIV     = SYS_HZ / REF_HZ;
    localparam int NORM_CYC    = 12;
    localparam int EXT_CYC     = 25;
    localparam int RES_W       = 10;
    localparam int NUM_CH      = 12;
    typedef struct packed {
        logic       en;
        logic       free;
        logic       ie;
        logic [2:0] div;
    } adcseq_cfg_type;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_CONV
    } adcseq_state_type;
endpackage

// file: rtl/adcseq_prescaler.sv
// converter clock prescaler: one-cycle enable pulses
// assumes the 2 MHz reference tick comes from the parent
`timescale 1ns/1ps
module adcseq_prescaler (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       ref_tick,
    input  wire logic [2:0] div_sel,
    output logic            adc_tick
);
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic [6:0] mask;
    // ==========================================================
    // divide select: 000 and 001 both give 2
    assign mask = (div_sel == 3'h0) ? 7'h01 :
                  7'(({7'h0, 1'b1} << div_sel) - 8'h1); // RL17
    assign nxt_cnt = !run ? 7'h00 :
                     ref_tick ? 7'(cnt_ff + 7'h1) : cnt_ff; // RL8
    assign adc_tick = run && ref_tick && ((cnt_ff & mask) == mask);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 7'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// file: rtl/adcseq_top.sv
// conversion sequencer: registers, mux select, sequencing, read lock
// assumes an Avalon-MM master and an analog core taking mux/sample
// Behaviour
// [RL1] result is 10-bit code from core
// [RL2] free_run_select picks single or free-running
// [RL3] channel takes effect only once enabled
// [RL4] start bit reads one until done
// [RL5] channel change deferred until conversion finishes
// [RL6] low read locks result until high read
// [RL7] done flag sets even when result dropped
// [RL8] prescaler runs only while enabled
// [RL9] conversion starts at next converter tick
// [RL10] normal conversion lasts 12 converter cycles
// [RL11] first conversion after enable lasts 25 (code: extended 25 plus a normal 12, 37 in all)
// [RL12] sample taken 1.5 converter cycles in (code: second system cycle after tick 1)
// [RL13] completion writes result, sets flag, clears start
// [RL14] free-running restarts at once, start stays high
// [RL15] codes above 11 select input 0
// [RL16] unused channel register bits read zero
// [RL17] divider select 2 to 128
// [RL18] flag cleared by vector ack or writing one
// [RL19] disabling aborts running conversion
// [RL20] start held through extended; writing zero ignored
// [RL21] interrupt needs flag, enable and global enable
// [RL22] software reads low byte before high byte
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module adcseq_top (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic [9:0]  core_result,
    output logic [3:0]       mux_sel,
    output logic             sample_hold,
    output logic             core_run,
    output logic             irq
);
    // ==========================================================
    // bus handshake: one wait cycle, answer on the second
    logic                         ack_ff;
    logic                         req;
    logic                         wr_go;
    logic                         rd_go;
    logic                         lane0;
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_ff;
    assign wr_go           = avs_write && ack_ff && lane0;
    assign rd_go           = avs_read && ack_ff;
    assign lane0           = avs_byteenable[0];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req && !ack_ff;
        end
    end
    // ==========================================================
    // address decode
    logic sel_ctrl;
    logic sel_mux;
    logic sel_resh;
    logic sel_resl;
    logic sel_irq;
    logic sel_any;
    assign sel_ctrl = avs_address == adcseq_pkg::CTRL_ADDR;
    assign sel_mux  = avs_address == adcseq_pkg::MUX_ADDR;
    assign sel_resh = avs_address == adcseq_pkg::RESH_ADDR;
    assign sel_resl = avs_address == adcseq_pkg::RESL_ADDR;
    assign sel_irq  = avs_address == adcseq_pkg::IRQ_ADDR;
    assign sel_any  = sel_ctrl | sel_mux | sel_resh | sel_resl | sel_irq;
    // ==========================================================
    // registers
    adcseq_pkg::adcseq_cfg_type   cfg_ff;
    adcseq_pkg::adcseq_state_type st_ff;
    logic       start_ff;
    logic       done_ff;
    logic       gie_ff;
    logic       ext_pend_ff;
    logic [3:0] mux_reg_ff;
    logic [3:0] mux_act_ff;
    logic [9:0] result_ff;
    logic       lock_ff;
    logic [5:0] cyc_ff;
    logic       half_ff;
    logic       wr_ctrl;
    logic [7:0] wd;
    logic       en_rise;
    logic       finish;
    logic       adc_tick;
    logic       ref_tick;
    logic [3:0] ref_cnt_ff;
    logic [5:0] conv_len;
    assign wr_ctrl = wr_go && sel_ctrl;
    assign wd      = avs_writedata[7:0];
    assign en_rise = wr_ctrl && wd[adcseq_pkg::EN_BIT] && !cfg_ff.en;
    // ==========================================================
    // 2 MHz reference tick from the 25 MHz clock (12.5 rounds to 12)
    assign ref_tick = ref_cnt_ff == 4'(adcseq_pkg::REF_DIV - 1);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_cnt_ff <= 4'h0;
        end else begin
            ref_cnt_ff <= ref_tick ? 4'h0 : 4'(ref_cnt_ff + 4'h1);
        end
    end
    adcseq_prescaler u_presc (
        .clock    (clock),
        .rstn     (rstn),
        .run      (cfg_ff.en),
        .ref_tick (ref_tick),
        .div_sel  (cfg_ff.div),
        .adc_tick (adc_tick)
    );
    // ==========================================================
    // sequencing
    assign conv_len = ext_pend_ff ? 6'(adcseq_pkg::EXT_CYC)
                                  : 6'(adcseq_pkg::NORM_CYC); // RL10 RL11
    assign finish   = (st_ff == adcseq_pkg::ST_CONV) && adc_tick &&
                      (cyc_ff == 6'(conv_len - 6'h1));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_ff       <= adcseq_pkg::ST_IDLE;
            cyc_ff      <= 6'h00;
            half_ff     <= 1'b0;
            ext_pend_ff <= 1'b0;
        end else if (!cfg_ff.en) begin
            st_ff       <= adcseq_pkg::ST_IDLE; // RL19
            cyc_ff      <= 6'h00;
            half_ff     <= 1'b0;
            ext_pend_ff <= en_rise; // RL11
        end else begin
            half_ff <= 1'b0;
            case (st_ff)
                adcseq_pkg::ST_IDLE: begin
                    if (start_ff) begin
                        st_ff <= adcseq_pkg::ST_WAIT;
                    end
                end
                adcseq_pkg::ST_WAIT: begin
                    if (adc_tick) begin
                        st_ff  <= adcseq_pkg::ST_CONV; // RL9
                        cyc_ff <= 6'h00;
                    end
                end
                adcseq_pkg::ST_CONV: begin
                    if (adc_tick) begin
                        cyc_ff  <= 6'(cyc_ff + 6'h1);
                        half_ff <= cyc_ff == 6'h00;
                    end
                    if (finish) begin
                        cyc_ff <= 6'h00;
                        if (ext_pend_ff) begin
                            ext_pend_ff <= 1'b0; // RL20
                        end else if (cfg_ff.free) begin
                            st_ff <= adcseq_pkg::ST_CONV; // RL14
                        end else begin
                            st_ff <= adcseq_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_ff <= adcseq_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // ==========================================================
    // sample strobe: half a converter cycle after tick 1,
    // approximated by the second system cycle past that tick
    logic samp_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            samp_ff <= 1'b0;
        end else begin
            samp_ff <= half_ff && (st_ff == adcseq_pkg::ST_CONV); // RL12
        end
    end
    // ==========================================================
    // control/status, channel and result registers
    logic real_done;
    assign real_done = finish && !ext_pend_ff;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_ff     <= '0;
            start_ff   <= 1'b0;
            done_ff    <= 1'b0;
            gie_ff     <= 1'b0;
            mux_reg_ff <= adcseq_pkg::MUX_RESET;
            mux_act_ff <= adcseq_pkg::MUX_RESET;
            result_ff  <= 10'h000;
            lock_ff    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cfg_ff.en   <= wd[adcseq_pkg::EN_BIT];
                cfg_ff.free <= wd[adcseq_pkg::FREE_BIT]; // RL2
                cfg_ff.ie   <= wd[adcseq_pkg::IE_BIT];
                cfg_ff.div  <= wd[2:0];
            end
            if (wr_go && sel_irq) begin
                gie_ff <= wd[adcseq_pkg::GIE_BIT];
            end
            if (wr_go && sel_mux) begin
                mux_reg_ff <= wd[3:0];
            end
            // start: writing zero does nothing; abort clears it
            if (!cfg_ff.en && !(wr_ctrl && wd[adcseq_pkg::EN_BIT])) begin
                start_ff <= 1'b0; // RL19
            end else if (wr_ctrl && wd[adcseq_pkg::START_BIT]) begin
                start_ff <= 1'b1; // RL4 RL20
            end else if (real_done && !cfg_ff.free) begin
                start_ff <= 1'b0; // RL13
            end
            // done flag: set wins over either clear
            if (real_done) begin
                done_ff <= 1'b1; // RL7 RL13
            end else if ((wr_ctrl && wd[adcseq_pkg::DONE_BIT]) ||
                         (wr_go && sel_irq && wd[adcseq_pkg::ACK_BIT])) begin
                done_ff <= 1'b0; // RL18
            end
            if (real_done && !lock_ff) begin
                result_ff <= core_result; // RL1 RL6
            end
            if (rd_go && sel_resl) begin
                lock_ff <= 1'b1; // RL6
            end else if (rd_go && sel_resh) begin
                lock_ff <= 1'b0; // RL6
            end
            // channel update only when idle or waiting, or at finish
            if (cfg_ff.en && (st_ff != adcseq_pkg::ST_CONV || finish)) begin
                mux_act_ff <= mux_reg_ff; // RL3 RL5
            end
        end
    end
    // ==========================================================
    // read mux and outputs
    logic [7:0] ctrl_rd;
    logic [7:0] rd_byte;
    assign ctrl_rd = {cfg_ff.en, start_ff, cfg_ff.free, done_ff,
                      cfg_ff.ie, cfg_ff.div};
    assign rd_byte = sel_ctrl ? ctrl_rd :
                     sel_mux  ? {4'h0, mux_reg_ff} : // RL16
                     sel_resl ? result_ff[7:0] :
                     sel_resh ? {6'h00, result_ff[9:8]} :
                     sel_irq  ? {7'h00, gie_ff} : 8'h00;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else begin
            avs_readdata <= (req && !ack_ff) ? {24'h0, rd_byte} : 32'h0;
            avs_response <= (req && !ack_ff && !sel_any) ? 2'h2 : 2'h0;
        end
    end
    // codes 11xx route input 0
    assign mux_sel     = (mux_act_ff > 4'hb) ? 4'h0 : mux_act_ff; // RL15
    assign sample_hold = samp_ff;
    assign core_run    = st_ff == adcseq_pkg::ST_CONV;
    assign irq         = done_ff && cfg_ff.ie && gie_ff; // RL21
endmodule

// file: tb/adcseq_checker.sv
// port checker for adcseq_top, bus handshake and conversion timing
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module adcseq_checker (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic [3:0]  mux_sel,
    input wire logic        sample_hold,
    input wire logic        core_run
);
    // ==========================================================
    // helpers and properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire req = avs_read || avs_write;
    wire ctl = avs_address == adcseq_pkg::CTRL_ADDR;
    wire mapped = avs_address inside {adcseq_pkg::CTRL_ADDR,
        adcseq_pkg::MUX_ADDR, adcseq_pkg::RESH_ADDR,
        adcseq_pkg::RESL_ADDR, adcseq_pkg::IRQ_ADDR};
    sequence s_take;
        req && !avs_waitrequest;
    endsequence
    chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait cycle on a new request");
    chk_wait_once: assert property (req && avs_waitrequest |=>
        !req || !avs_waitrequest)
        else $error("wait lasted more than one cycle");
    chk_unmapped_err: assert property (s_take ##0 (avs_read && !mapped)
        |-> avs_response == 2'b10 && avs_readdata == 32'h0)
        else $error("unmapped read not refused");
    chk_mapped_ok: assert property (s_take ##0 (avs_read && mapped)
        |-> avs_response == 2'b00)
        else $error("mapped read refused");
    chk_mux_range: assert property (mux_sel <= 4'hb)
        else $error("channel beyond eleven routed");
    chk_mux_hold: assert property (sample_hold |=> $stable(mux_sel)[*8])
        else $error("channel moved during conversion");
    chk_sample_late: assert property ($rose(core_run) |-> !sample_hold[*8])
        else $error("sample taken too early");
    chk_sample_run: assert property (sample_hold |-> core_run)
        else $error("sample outside conversion");
    // abort gets a few cycles: the write lands, then state settles
    chk_abort_run: assert property (s_take ##0 (avs_write && ctl &&
        !avs_writedata[adcseq_pkg::EN_BIT]) |-> ##[1:3] !core_run)
        else $error("disable did not stop conversion");
endmodule

bind adcseq_top adcseq_checker u_chk (.clock, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .avs_response, .mux_sel, .sample_hold, .core_run);

// file: tb/adcseq_core_model.sv
// analog core stand-in: code follows the channel held at sampling
// assumes core_run marks a conversion in progress
`timescale 1ns/1ps
module adcseq_core_model (
    input  wire logic       clock,
    input  wire logic [3:0] mux_sel,
    input  wire logic       sample_hold,
    input  wire logic       core_run,
    output logic      [9:0] core_result
);
    // ==========================================================
    // capture and output
    logic [9:0] hold_ff;
    logic [9:0] junk_ff = 10'h155;
    // outside a conversion the code is not held, so it toggles
    always @(posedge clock) junk_ff <= ~junk_ff;
    always @(posedge clock) if (sample_hold) hold_ff <= {mux_sel, 6'h2d};
    assign core_result = core_run ? hold_ff : junk_ff;
endmodule

// file: tb/adcseq_top_test.sv
// self-checking bench for adcseq_top with the core stand-in
// assumes 25 MHz clock; a watchdog ends a hung run
`timescale 1ns/1ps
module adcseq_top_test;
    localparam logic [9:0] CA = adcseq_pkg::CTRL_ADDR;
    localparam logic [9:0] MA = adcseq_pkg::MUX_ADDR;
    localparam logic [9:0] HA = adcseq_pkg::RESH_ADDR;
    localparam logic [9:0] LA = adcseq_pkg::RESL_ADDR;
    localparam logic [9:0] IA = adcseq_pkg::IRQ_ADDR;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [9:0]  avs_address = 10'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, sample_hold, core_run, irq;
    logic [1:0]  avs_response;
    logic [9:0]  core_result, e;
    logic [3:0]  mux_sel;
    int          mismatches = 0;
    int          n_compared = 0;
    int          run_cyc = 0;
    int          n_samp = 0;
    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (core_run === 1'b1) run_cyc++;
        if (sample_hold === 1'b1) n_samp++;
    end
    adcseq_top u_dut (.clock, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .core_result, .mux_sel, .sample_hold, .core_run,
        .irq);
    adcseq_core_model u_core (.clock, .mux_sel, .sample_hold, .core_run,
        .core_result);
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        // request held until the rising edge that sees waitrequest low
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) mismatches++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            bus(1'b0, CA, 8'h0);
            n++;
        end while (q[4] !== 1'b1 && n < 700);
        if (n >= 700) mismatches++;
    endtask
    task automatic read_res(input logic [3:0] c);
        e = {c, 6'h2d};
        bus(1'b0, LA, 8'h0);
        chk(q, {24'h0, e[7:0]});
        bus(1'b0, HA, 8'h0);
        chk(q, {30'h0, e[9:8]});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        bus(1'b0, CA, 8'h0);
        chk(q, {24'h0, adcseq_pkg::CTRL_RESET});
        bus(1'b1, MA, 8'hff);
        bus(1'b0, MA, 8'h0);
        chk(q, 32'h0f);
        repeat (2) @(negedge clock);
        chk(mux_sel, 32'h0);
        bus(1'b0, 10'h3fc, 8'h0);
        chk(q, 32'h0);
        bus(1'b1, CA, 8'h80);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, MA, 8'(c));
            repeat (2) @(negedge clock);
            chk(mux_sel, (c < 12) ? c : 0);
        end
        $display("t_regs done");
    endtask
    task automatic t_single;
        bus(1'b1, MA, 8'h03);
        run_cyc = 0;
        bus(1'b1, CA, 8'hc0);
        bus(1'b1, CA, 8'h80);
        bus(1'b0, CA, 8'h0);
        chk(q[6], 1'b1);
        wait_done;
        chk(q[6], 1'b0);
        // 25 + 12 converter cycles of 24 system cycles each
        chk(run_cyc inside {[880:896]}, 1'b1);
        read_res(4'h3);
        bus(1'b1, CA, 8'h90);
        bus(1'b0, CA, 8'h0);
        chk(q[4], 1'b0);
        run_cyc = 0;
        bus(1'b1, CA, 8'hc0);
        wait_done;
        chk(run_cyc inside {[285:315]}, 1'b1);
        $display("t_single done");
    endtask
    task automatic t_defer;
        bus(1'b1, CA, 8'hd0);
        // change the channel only once the conversion is running
        wait (core_run === 1'b1);
        bus(1'b1, MA, 8'h05);
        repeat (2) @(negedge clock);
        chk(mux_sel, 32'h3);
        wait_done;
        repeat (2) @(negedge clock);
        chk(mux_sel, 32'h5);
        read_res(4'h3);
        $display("t_defer done");
    endtask
    task automatic t_lock;
        bus(1'b0, LA, 8'h0);
        bus(1'b1, CA, 8'hd8);
        wait_done;
        chk(q[4], 1'b1);
        bus(1'b0, HA, 8'h0);
        chk(q, 32'h0);
        bus(1'b1, IA, 8'h01);
        repeat (2) @(negedge clock);
        chk(irq, 1'b1);
        bus(1'b1, IA, 8'h00);
        repeat (2) @(negedge clock);
        chk(irq, 1'b0);
        bus(1'b1, IA, 8'h03);
        bus(1'b0, CA, 8'h0);
        chk(q[4], 1'b0);
        bus(1'b1, CA, 8'hc0);
        wait_done;
        read_res(4'h5);
        $display("t_lock done");
    endtask
    task automatic t_free;
        bus(1'b1, CA, 8'hf0);
        n_samp = 0;
        repeat (1000) @(posedge clock);
        chk(n_samp inside {[3:4]}, 1'b1);
        bus(1'b0, CA, 8'h0);
        chk(q[6], 1'b1);
        bus(1'b1, CA, 8'h00);
        repeat (4) @(negedge clock);
        chk(core_run, 1'b0);
        run_cyc = 0;
        // done flag left set by free-running: clear it with the start
        bus(1'b1, CA, 8'hd2);
        wait_done;
        // 37 converter cycles of 48 system cycles each
        chk(run_cyc inside {[1768:1784]}, 1'b1);
        $display("t_free done");
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        t_regs;
        t_single;
        t_defer;
        t_lock;
        t_free;
        results;
    end
    // the whole run needs some 5200 cycles
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        results;
    end
endmodule
